/* File: rtl/mdc_pkg.sv */
// package: constants and types for the serial dac control decode
package mdc_pkg;
	localparam int WORD_BITS = 16;
	localparam int MAIN_BITS = 10;
	localparam int SUB_BITS = 8;
	// word field positions
	localparam int POS_MAIN_SUB = 15;
	localparam int POS_TYPE_LO = 14;
	localparam int POS_TYPE_HI = 13;
	localparam int POS_ADDR_HI = 12;
	localparam int POS_ADDR_LO = 10;
	localparam int POS_BIAS_HI = 9;
	localparam int POS_BIAS_LO = 8;
	localparam int POS_CHAN_STANDBY_N = 4;
	localparam int POS_CLR = 3;
	localparam int POS_CODING = 6;
	localparam int POS_PD = 5;
	localparam int POS_ALL_STANDBY = 4;
	localparam int POS_ALL_SOFT_CLEAR = 3;
	localparam int POS_SUB_LO = 2;
	// reset values
	localparam logic RST_POWER_DOWN_N = 1'h1;
	localparam logic RST_ALL_STANDBY = 1'h1;
	localparam logic RST_CODING = 1'h0;
	localparam logic RST_ALL_CLEAR = 1'h0;
	localparam logic RST_CHAN_CHAN_STANDBY_N_N = 1'h1;
	localparam logic RST_CHAN_CLEAR = 1'h1;
	localparam logic [1:0] RST_BIAS = 2'h0;
	// clear codes
	localparam logic [9:0] CLR_TWOS = 10'h000;
	localparam logic [9:0] CLR_OBIN = 10'h000;
	localparam logic [9:0] MID_TWOS_INFO = 10'h200;
	localparam logic [7:0] SUB_RST = 8'h00;
	localparam logic [4:0] BIT_COUNT_LAST = 5'h10;

	typedef enum logic [1:0] {
		MDC_BIAS_HALF_SUPPLY,
		MDC_BIAS_INTERNAL,
		MDC_BIAS_EXTERNAL,
		MDC_BIAS_UNDEFINED
	} mdc_bias_t;

	typedef struct packed {
		logic power_down_n;
		logic coding_select;
		logic all_standby;
		logic all_soft_clear;
	} mdc_global_t;

	typedef struct packed {
		logic chan_standby_n;
		logic chan_soft_clear;
		logic [1:0] bias_select;
	} mdc_chan_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} mdc_word_t;
endpackage

/* File: rtl/mdc_serial_rx.sv */
// serial shift receiver: syncs link pins and assembles 16-bit words
`timescale 1ns/1ps
module mdc_serial_rx (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_sync_n,
	input wire logic clk_en,
	// link pins
	input wire logic serial_shift_clock,
	input wire logic frame_sync_n,
	input wire logic serial_data_in,
	// assembled word
	output mdc_pkg::mdc_word_t word_out
);
	import mdc_pkg::*;

	logic [2:0] sck_reg, sck_next;
	logic [2:0] fs_reg, fs_next;
	logic [2:0] sd_reg, sd_next;
	logic [15:0] shift_reg, shift_next;
	logic [4:0] count_reg, count_next;
	mdc_word_t word_reg, word_next;
	logic fall;
	logic frame_on;

	always_comb begin
		sck_next = {sck_reg[1:0], serial_shift_clock};
		fs_next = {fs_reg[1:0], frame_sync_n};
		sd_next = {sd_reg[1:0], serial_data_in};
		// falling edge when the second stage has gone low and the third is still high
		fall = sck_reg[2] & ~sck_reg[1];
		frame_on = ~fs_reg[1];
		shift_next = shift_reg;
		count_next = count_reg;
		word_next = word_reg;
		word_next.valid = 1'b0;
		if (!frame_on) begin
			count_next = 5'h00;
		end else if (fall && count_reg != BIT_COUNT_LAST) begin
			shift_next = {shift_reg[14:0], sd_reg[1]}; // msb first
			count_next = count_reg + 5'h01;
			if (count_reg == BIT_COUNT_LAST - 5'h01) begin
				word_next.valid = 1'b1; // full word only
				word_next.data = {shift_reg[14:0], sd_reg[1]};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// shift clock idles high, so no false edge after reset
			sck_reg <= 3'h7;
			fs_reg <= 3'h7;
			sd_reg <= 3'h0;
			shift_reg <= 16'h0000;
			count_reg <= 5'h00;
			word_reg <= '0;
		end else if (clk_en) begin
			sck_reg <= sck_next;
			fs_reg <= fs_next;
			sd_reg <= sd_next;
			shift_reg <= shift_next;
			count_reg <= count_next;
			word_reg <= word_next;
		end
	end

	assign word_out = word_reg;

	bit_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		count_reg <= BIT_COUNT_LAST) else $error("bit count overran");
	cover_word_c: cover property (@(posedge clk_sys) word_reg.valid);
endmodule // mdc_serial_rx

/* File: rtl/mdc_decode.sv */
// top: decodes serial words into global, channel and dac registers
// Contract
// - power_down_n written 0 puts reference and all dacs in low power
// - power_down_n 1 restores operation; registers keep contents throughout
// - coding_select sets coding for all dacs: 0 twos, 1 offset binary
// - all_standby 1 puts every dac in standby, reference stays up
// - all_standby 0 takes all dacs out of standby
// - all_soft_clear 1 clears main data and dac registers of all channels
// - clear value is midscale in twos, bottom code in offset binary
// - global clear leaves sub dac data untouched
// - three address bits pick channel; quad ignores the top bit
// - chan_standby_n 0 puts only addressed dac in standby
// - chan_standby_n 1 returns addressed dac to normal
// - chan_soft_clear clears only addressed main dac, sub untouched
// - bias_select: 00 half supply, 01 internal, 10 external, 11 undefined
// - data word bit 15: 1 sub data, 0 main data
// - sub data is 8 bits, two low word bits ignored
// - sub code uses same coding as main dac
// - word type bits route to global, channel or data registers
// - bits shift in msb first on falling serial clock while frame low
// - load_outputs_n falling edge loads all dac registers from data registers
// - power up in standby with documented defaults
`timescale 1ns/1ps
module mdc_decode #(
	parameter int CHANNELS = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// serial link
	input wire logic serial_shift_clock,
	input wire logic frame_sync_n,
	input wire logic serial_data_in,
	input wire logic load_outputs_n,
	// global state
	output mdc_pkg::mdc_global_t global_out,
	output logic ref_powered,
	// per channel state
	output mdc_pkg::mdc_chan_t [CHANNELS-1:0] chan_out,
	output logic [CHANNELS-1:0] chan_active,
	output logic [CHANNELS*10-1:0] main_dac_out,
	output logic [CHANNELS*8-1:0] sub_dac_out
);
	import mdc_pkg::*;

	localparam int AW = (CHANNELS > 4) ? 3 : 2;

	logic [1:0] rst_sync;
	logic rst_sync_n;
	mdc_word_t word;
	logic [2:0] ld_reg, ld_next;

	mdc_global_t glob_reg, glob_next;
	mdc_chan_t [CHANNELS-1:0] chan_reg, chan_next;
	logic [9:0] main_data_reg [CHANNELS], main_data_next [CHANNELS];
	logic [7:0] sub_data_reg [CHANNELS], sub_data_next [CHANNELS];
	logic [9:0] main_dac_reg [CHANNELS], main_dac_next [CHANNELS];
	logic [7:0] sub_dac_reg [CHANNELS], sub_dac_next [CHANNELS];
	logic [CHANNELS-1:0] act_reg, act_next;
	logic ref_reg, ref_next;
	logic [AW-1:0] addr;
	logic [9:0] clear_code;
	logic load_fall;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync[1];

	mdc_serial_rx u_rx (
		.clk_sys(clk_sys),
		.rst_sync_n(rst_sync_n),
		.clk_en(clk_en),
		.serial_shift_clock(serial_shift_clock),
		.frame_sync_n(frame_sync_n),
		.serial_data_in(serial_data_in),
		.word_out(word)
	);

	always_comb begin
		ld_next = {ld_reg[1:0], load_outputs_n};
		load_fall = ld_reg[2] & ~ld_reg[1];
		// quad part ignores the top address bit
		addr = word.data[POS_ADDR_LO +: AW];
		// twos complement midscale is code zero, offset binary bottom is zero too
		clear_code = glob_reg.coding_select ? CLR_OBIN : CLR_TWOS;
		glob_next = glob_reg;
		chan_next = chan_reg;
		main_data_next = main_data_reg;
		sub_data_next = sub_data_reg;
		main_dac_next = main_dac_reg;
		sub_dac_next = sub_dac_reg;
		if (word.valid) begin
			if (!word.data[POS_TYPE_HI] && !word.data[POS_TYPE_LO]) begin
				// global word, address ignored
				glob_next.power_down_n = word.data[POS_PD];
				glob_next.coding_select = word.data[POS_CODING];
				glob_next.all_standby = word.data[POS_ALL_STANDBY];
				glob_next.all_soft_clear = word.data[POS_ALL_SOFT_CLEAR];
			end else if (!word.data[POS_TYPE_HI]) begin
				chan_next[addr].chan_standby_n = word.data[POS_CHAN_STANDBY_N];
				chan_next[addr].chan_soft_clear = word.data[POS_CLR];
				chan_next[addr].bias_select =
					word.data[POS_BIAS_HI:POS_BIAS_LO];
			end else if (word.data[POS_MAIN_SUB]) begin
				sub_data_next[addr] = word.data[POS_SUB_LO +: SUB_BITS];
			end else begin
				main_data_next[addr] = word.data[MAIN_BITS-1:0];
			end
		end
		for (int i = 0; i < CHANNELS; i++) begin
			if (load_fall) begin
				main_dac_next[i] = main_data_next[i];
				sub_dac_next[i] = sub_data_next[i];
				if (chan_reg[i].chan_soft_clear) begin
					// channel clear applied by the load strobe
					main_dac_next[i] = clear_code;
				end
			end
			if (glob_next.all_soft_clear) begin
				// sub data left alone
				main_data_next[i] = clear_code;
				main_dac_next[i] = clear_code;
			end
			act_next[i] = glob_reg.power_down_n & ~glob_reg.all_standby
				& chan_reg[i].chan_standby_n;
		end
		ref_next = glob_reg.power_down_n;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ld_reg <= 3'h7;
			glob_reg <= '{RST_POWER_DOWN_N, RST_CODING, RST_ALL_STANDBY,
				RST_ALL_CLEAR};
			for (int i = 0; i < CHANNELS; i++) begin
				chan_reg[i] <= '{RST_CHAN_CHAN_STANDBY_N_N, RST_CHAN_CLEAR, RST_BIAS};
				main_data_reg[i] <= CLR_TWOS;
				sub_data_reg[i] <= SUB_RST;
				main_dac_reg[i] <= CLR_TWOS;
				sub_dac_reg[i] <= SUB_RST;
			end
			act_reg <= '0;
			ref_reg <= 1'b0;
		end else if (clk_en) begin
			ld_reg <= ld_next;
			glob_reg <= glob_next;
			chan_reg <= chan_next;
			main_data_reg <= main_data_next;
			sub_data_reg <= sub_data_next;
			main_dac_reg <= main_dac_next;
			sub_dac_reg <= sub_dac_next;
			act_reg <= act_next;
			ref_reg <= ref_next;
		end
	end

	always_comb begin
		global_out = glob_reg;
		chan_out = chan_reg;
		chan_active = act_reg;
		ref_powered = ref_reg;
		for (int i = 0; i < CHANNELS; i++) begin
			main_dac_out[i*10 +: 10] = main_dac_reg[i];
			sub_dac_out[i*8 +: 8] = sub_dac_reg[i];
		end
	end

	standby_all_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && glob_reg.all_standby |=> act_reg == '0)
		else $error("dac active during all standby");
	pd_ref_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && !glob_reg.power_down_n |=> !ref_reg)
		else $error("reference on in power down");
	all_soft_clear_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && glob_reg.all_soft_clear && !load_fall && !word.valid
		|=> $stable(sub_data_reg[0]))
		else $error("sub data changed on clear");
	all_soft_clear_main_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && glob_next.all_soft_clear |=> main_dac_reg[0] == $past(clear_code))
		else $error("main not cleared");
	load_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && load_fall && !glob_next.all_soft_clear && !chan_reg[0].chan_soft_clear
		|=> main_dac_reg[0] == main_data_reg[0])
		else $error("load did not copy data");
	gw_keep_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && word.valid && word.data[POS_TYPE_HI] |=> $stable(chan_reg))
		else $error("data word touched channel control");
	chan_standby_n_act_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && !chan_reg[0].chan_standby_n |=> !act_reg[0])
		else $error("standby channel active");
	main_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		clk_en && word.valid && word.data[POS_TYPE_HI] && !word.data[POS_MAIN_SUB]
		&& addr == '0 && !glob_next.all_soft_clear
		|=> main_data_reg[0] == $past(word.data[9:0]))
		else $error("main data not written");
	cover_glob_c: cover property (@(posedge clk_sys) word.valid && word.data[15:13] == 3'h0);
	cover_load_c: cover property (@(posedge clk_sys) load_fall);
	cover_sub_c: cover property (@(posedge clk_sys) word.valid && word.data[15]
		&& word.data[13]);
endmodule // mdc_decode

/* File: verif/mdc_host_model.sv */
// host model: drives serial frames and the load strobe
`timescale 1ns/1ps
module mdc_host_model (
	// clock
	input wire logic clk_sys,
	// link pins
	output logic serial_shift_clock,
	output logic frame_sync_n,
	output logic serial_data_in,
	output logic load_outputs_n
);
	initial begin
		serial_shift_clock = 1'b1;
		frame_sync_n = 1'b1;
		serial_data_in = 1'b0;
		load_outputs_n = 1'b1;
	end

	task automatic half();
		repeat (4) @(negedge clk_sys);
	endtask

	// n below 16 gives an aborted frame
	task automatic send(input logic [15:0] w, input int n);
		frame_sync_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			serial_data_in = w[i];
			half();
			serial_shift_clock = 1'b0;
			half();
			serial_shift_clock = 1'b1;
		end
		half();
		frame_sync_n = 1'b1;
		// released line must not keep its last value
		serial_data_in = ~serial_data_in;
		half();
	endtask

	task automatic load_pulse();
		load_outputs_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		load_outputs_n = 1'b1;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule // mdc_host_model

/* File: verif/testbench.sv */
// bench: serial word scenarios against the dac control decode
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
	import mdc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic serial_shift_clock, frame_sync_n, serial_data_in, load_outputs_n;
	mdc_global_t global_out;
	logic ref_powered;
	mdc_chan_t [7:0] chan_out;
	logic [7:0] chan_active;
	logic [79:0] main_dac_out, exp_main;
	logic [63:0] sub_dac_out, exp_sub;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	always #10 clk_sys = ~clk_sys;
	mdc_decode #(.CHANNELS(8)) mdc_decode_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(clk_en), .serial_shift_clock(serial_shift_clock),
		.frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
		.load_outputs_n(load_outputs_n), .global_out(global_out),
		.ref_powered(ref_powered), .chan_out(chan_out), .chan_active(chan_active),
		.main_dac_out(main_dac_out), .sub_dac_out(sub_dac_out));
	mdc_host_model mdc_host_model_i (.clk_sys(clk_sys),
		.serial_shift_clock(serial_shift_clock), .frame_sync_n(frame_sync_n),
		.serial_data_in(serial_data_in), .load_outputs_n(load_outputs_n));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [15:0] w);
		mdc_host_model_i.send(w, 16);
		repeat (8) @(negedge clk_sys);
	endtask

	function automatic logic [15:0] cw(input int a, input logic [1:0] b, input logic s,
		input logic c);
		return {3'b010, 3'(a), b, 3'b000, s, c, 3'b000};
	endfunction

	initial begin
		exp_main = '0;
		exp_sub = '0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK("global", 4'hA, global_out)
		`CHK("chan", {8{4'hC}}, chan_out)
		`CHK("active", 8'h00, chan_active)
		wr(16'h0060);
		`CHK("global", 4'hC, global_out)
		wr(16'h0020);
		`CHK("global", 4'h8, global_out)
		`CHK("ref", 1'b1, ref_powered)
		for (int a = 0; a < 8; a++) begin
			wr(cw(a, 2'(a), 1'b1, 1'b0));
			`CHK("chan", ({2'b10, 2'(a)}), chan_out[a])
		end
		`CHK("chan", 32'hBA98BA98, chan_out)
		`CHK("active", 8'hFF, chan_active)
		for (int a = 0; a < 8; a++) begin
			exp_main[a*10+:10] = 10'(a * 93 + 7);
			exp_sub[a*8+:8] = 8'(a * 29 + 128);
			wr({3'b001, 3'(a), exp_main[a*10+:10]});
			wr({3'b101, 3'(a), exp_sub[a*8+:8], 2'b11});
		end
		`CHK("main", 80'h0, main_dac_out)
		mdc_host_model_i.load_pulse();
		`CHK("main", exp_main, main_dac_out)
		`CHK("sub", exp_sub, sub_dac_out)
		wr(cw(0, 2'h0, 1'b0, 1'b0));
		`CHK("active", 8'hFE, chan_active)
		wr(cw(0, 2'h0, 1'b1, 1'b0));
		`CHK("active", 8'hFF, chan_active)
		wr(16'h0030);
		`CHK("active", 8'h00, chan_active)
		`CHK("ref", 1'b1, ref_powered)
		wr(16'h0020);
		`CHK("active", 8'hFF, chan_active)
		mdc_host_model_i.send(16'h0000, 8);
		repeat (8) @(negedge clk_sys);
		`CHK("ref", 1'b1, ref_powered)
		// frozen block must miss a whole frame
		clk_en = 1'b0;
		wr(16'h0000);
		clk_en = 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK("ref", 1'b1, ref_powered)
		`CHK("global", 4'h8, global_out)
		wr(16'h0000);
		`CHK("ref", 1'b0, ref_powered)
		`CHK("active", 8'h00, chan_active)
		wr(16'h0020);
		`CHK("ref", 1'b1, ref_powered)
		`CHK("main", exp_main, main_dac_out)
		`CHK("chan", 32'hBA98BA98, chan_out)
		wr(cw(5, 2'h1, 1'b1, 1'b1));
		mdc_host_model_i.load_pulse();
		exp_main[50+:10] = CLR_TWOS;
		`CHK("main", exp_main, main_dac_out)
		`CHK("sub", exp_sub, sub_dac_out)
		wr(16'h0068);
		`CHK("main", {8{CLR_OBIN}}, main_dac_out)
		`CHK("sub", exp_sub, sub_dac_out)
		wr(16'h0060);
		mdc_host_model_i.load_pulse();
		`CHK("main", {8{CLR_OBIN}}, main_dac_out)
		`CHK("sub", exp_sub, sub_dac_out)
		report_and_stop();
	end
endmodule // testbench
